// ===== rtl/mrc_pkg.sv
// Constants, carrier types and state layout of the reset control block.
// Functional notes
// - Five reset sources: pin, power-on, brown-out, software request, watchdog.
// - Power-on reset resets core, peripherals and the debug test port.
// - Pin reset resets core and peripherals; only test port pin config.
// - Brown-out reset acts like pin reset and holds while supply is low; here it leaves the test port pin config unreset.
// - Brown-out reset is disabled after power-on; software may enable it.
// - Brown-out causes system reset only when its enable bit is set.
// - With brown-out reset off, a brown-out raises an interrupt instead.
// - Each reset sets its cause bit; bits stay until software clears them.
// - Power-on reset clears every cause bit except the power-on bit.
// - Internal reset holds until the power-on detector is inactive, then releases.
// - Power-on detection acts only at initial power-up, never later.
// - Three peripheral reset registers; set then clear resets that peripheral only.
// - Peripheral reset bit positions equal the clock gating bit positions.
// - A peripheral reset asserts the reset of every clock of that unit.
// - System reset request resets whole system including core, not test port.
// - System request asserts internal reset, then releases it for boot.
// - Watchdog reset resets core and peripherals but not the test port.
// - Watchdog resets only on second time-out before clear, when enabled.
package mrc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int PRST_N = 3;
  localparam int PER_W  = PRST_N * DATA_W;
  localparam logic [ADDR_W-1:0] OFF_BOR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_CAUSE    = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_PRST0    = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_PRST1    = 12'h00c;
  localparam logic [ADDR_W-1:0] OFF_PRST2    = 12'h010;
  localparam logic [2:0] IDX_CTRL  = 3'h0;
  localparam logic [2:0] IDX_CAUSE = 3'h1;
  localparam logic [2:0] IDX_PRST0 = 3'h2;
  localparam logic [2:0] IDX_NONE  = 3'h7;
  localparam int BOR_EN_BIT = 1;
  localparam int CAUSE_W    = 5;
  localparam int CAUSE_EXT  = 0;
  localparam int CAUSE_POR  = 1;
  localparam int CAUSE_BOR  = 2;
  localparam int CAUSE_WDT  = 3;
  localparam int CAUSE_SW   = 4;
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 5'h02;
  localparam int CLK_PERIOD_NS = 4;
  localparam int RST_HOLD_NS   = 32;
  localparam int HOLD_W        = 4;
  localparam logic [HOLD_W-1:0] HOLD_CYCLES = HOLD_W'((RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef struct packed {
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } mrc_apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
  } mrc_apb_rsp_t;

  typedef struct packed {
    logic [1:0]                    ext_s;
    logic [1:0]                    bor_s;
    logic                          bor_en;
    logic [CAUSE_W-1:0]            cause;
    logic [PRST_N-1:0][DATA_W-1:0] prst;
    logic                          wdt_first;
    logic [HOLD_W-1:0]             hold_cnt;
    logic                          core_rst_n;
    logic [PER_W-1:0]              per_rst_n;
    logic                          test_rst_n;
    logic                          pincfg_rst_n;
    logic                          bor_irq;
    mrc_apb_rsp_t                  rsp;
  } mrc_state_t;

  localparam mrc_state_t STATE_RST = '{
    ext_s: 2'h3, bor_s: 2'h0, bor_en: 1'b0, cause: CAUSE_RST, prst: '0, wdt_first: 1'b0,
    hold_cnt: HOLD_CYCLES, core_rst_n: 1'b0, per_rst_n: '0, test_rst_n: 1'b0,
    pincfg_rst_n: 1'b0, bor_irq: 1'b0, rsp: '0};
endpackage

// ===== rtl/mrc_reset_control.sv
// Reset source combiner, cause recorder and internal reset sequencer with an APB register slave.
`timescale 1ns/10ps
module mrc_reset_control
  import mrc_pkg::*;
(
  // Clock and power-on reset.
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  // Pin and supply monitor.
  input  wire logic         ext_rst_n_in,
  input  wire logic         brown_out_in,
  // Core and watchdog, same clock.
  input  wire logic         sys_reset_req_in,
  input  wire logic         wdt_timeout_in,
  input  wire logic         wdt_int_clear_in,
  input  wire logic         wdt_reset_en_in,
  // Register bus.
  input  wire mrc_apb_req_t apb_req_in,
  output mrc_apb_rsp_t      apb_rsp_out,
  // Reset and interrupt outputs.
  output logic              core_rst_n_out,
  output logic [PER_W-1:0]  per_rst_n_out,
  output logic              test_rst_n_out,
  output logic              pincfg_rst_n_out,
  output logic              bor_irq_out
);

  mrc_state_t         s;
  mrc_state_t         n;
  logic               sys_active;
  logic               wdt_fire;
  logic               acc;
  logic               done;
  logic [2:0]         idx;
  logic [CAUSE_W-1:0] cause_set;
  logic [CAUSE_W-1:0] cause_clr;
  logic [PER_W-1:0]   prst_flat;

  function automatic logic [2:0] reg_idx(input logic [ADDR_W-1:0] a);
    logic [2:0] r;
    r = IDX_NONE;
    unique case (a)
      OFF_BOR_CTRL: r = IDX_CTRL;
      OFF_CAUSE:    r = IDX_CAUSE;
      OFF_PRST0:    r = IDX_PRST0;
      OFF_PRST1:    r = 3'(IDX_PRST0 + 3'h1);
      OFF_PRST2:    r = 3'(IDX_PRST0 + 3'h2);
      default:      r = IDX_NONE;
    endcase
    return r;
  endfunction

  function automatic logic [DATA_W-1:0] read_word(input mrc_state_t st, input logic [2:0] i);
    logic [DATA_W-1:0] d;
    d = '0;
    if (i == IDX_CTRL) begin
      d[BOR_EN_BIT] = st.bor_en;
    end else if (i == IDX_CAUSE) begin
      d[CAUSE_W-1:0] = st.cause;
    end else if (i != IDX_NONE) begin
      d = st.prst[2'(i - IDX_PRST0)];
    end
    return d;
  endfunction

  assign prst_flat = s.prst;

  always_comb begin
    n = s;
    // Only the second stage of each synchroniser is read below.
    n.ext_s = {s.ext_s[0], ext_rst_n_in};
    n.bor_s = {s.bor_s[0], brown_out_in};

    // A second time-out while the first is still pending is the watchdog reset.
    wdt_fire = wdt_timeout_in && s.wdt_first && wdt_reset_en_in;
    n.wdt_first = wdt_timeout_in || (s.wdt_first && !wdt_int_clear_in);

    // Sources that reset core and peripherals; the test port is left alone.
    sys_active = !s.ext_s[1] || (s.bor_s[1] && s.bor_en) || sys_reset_req_in || wdt_fire;

    // The register answer comes one cycle into the access phase.
    idx  = reg_idx(apb_req_in.paddr);
    acc  = apb_req_in.psel && apb_req_in.penable && !s.rsp.pready;
    done = apb_req_in.psel && apb_req_in.penable && s.rsp.pready;
    n.rsp.pready  = acc;
    n.rsp.pslverr = acc && (idx == IDX_NONE);
    n.rsp.prdata  = (acc && !apb_req_in.pwrite) ? read_word(s, idx) : '0;

    cause_clr = '0;
    if (done && apb_req_in.pwrite) begin
      if (idx == IDX_CTRL) begin
        n.bor_en = apb_req_in.pwdata[BOR_EN_BIT];
      end
      if (idx == IDX_CAUSE) begin
        cause_clr = apb_req_in.pwdata[CAUSE_W-1:0];
      end
      for (int k = 0; k < PRST_N; k++) begin
        if (idx == 3'(IDX_PRST0 + 3'(k))) begin
          n.prst[k] = apb_req_in.pwdata;
        end
      end
    end

    // A new cause wins over a clear written in the same cycle.
    cause_set = '0;
    cause_set[CAUSE_EXT] = !s.ext_s[1];
    cause_set[CAUSE_BOR] = s.bor_s[1] && s.bor_en;
    cause_set[CAUSE_WDT] = wdt_fire;
    cause_set[CAUSE_SW]  = sys_reset_req_in;
    n.cause = (s.cause & ~cause_clr) | cause_set;

    // The brown-out interrupt stands in for the reset while that is off.
    n.bor_irq = s.bor_s[1] && !s.bor_en;

    if (sys_active) begin
      n.hold_cnt  = HOLD_CYCLES;
      n.prst      = '0;
      n.wdt_first = 1'b0;
    end else if (s.hold_cnt != '0) begin
      n.hold_cnt = s.hold_cnt - HOLD_W'(1);
    end

    // Release only after the sources stay quiet for the whole hold time.
    n.core_rst_n   = !sys_active && (s.hold_cnt == '0);
    // Each bit is the single reset of all clocks of one unit, indexed as its clock gate.
    n.per_rst_n    = {PER_W{n.core_rst_n}} & ~prst_flat;
    // Only power-on reaches the test port; the pin touches its pin setup alone.
    n.test_rst_n   = 1'b1;
    n.pincfg_rst_n = s.ext_s[1];
  end

  // Power-on reset loads every field, including the cause word, from the reset image.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s <= STATE_RST;
    end else begin
      s <= n;
    end
  end

  assign apb_rsp_out      = s.rsp;
  assign core_rst_n_out   = s.core_rst_n;
  assign per_rst_n_out    = s.per_rst_n;
  assign test_rst_n_out   = s.test_rst_n;
  assign pincfg_rst_n_out = s.pincfg_rst_n;
  assign bor_irq_out      = s.bor_irq;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_quiet;
    !sys_active [*8];
  endsequence

  sequence s_hold_done;
    s_quiet ##1 !sys_active;
  endsequence

  a_ext_core: assert property (!s.ext_s[1] |=> !core_rst_n_out && s.cause[CAUSE_EXT])
    else $error("Pin reset did not hold the core.");
  a_test_kept: assert property ($past(test_rst_n_out) |-> test_rst_n_out)
    else $error("Test port reset rose after power-on.");
  a_bor_reset: assert property (s.bor_s[1] && s.bor_en |=> !core_rst_n_out [*2])
    else $error("Enabled brown-out did not hold reset.");
  a_bor_irq: assert property (s.bor_s[1] && !s.bor_en |=> bor_irq_out)
    else $error("Brown-out interrupt missing.");
  a_bor_default: assert property ($rose(test_rst_n_out) |-> !s.bor_en && !bor_irq_out)
    else $error("Brown-out reset enabled after power-on.");
  a_wdt_fire: assert property (wdt_timeout_in && s.wdt_first && wdt_reset_en_in
    |=> !core_rst_n_out && s.cause[CAUSE_WDT] && test_rst_n_out)
    else $error("Second watchdog time-out did not reset.");
  a_sw_request: assert property (sys_reset_req_in |=> !core_rst_n_out && s.cause[CAUSE_SW])
    else $error("System request did not reset.");
  a_hold_release: assert property (s_hold_done |=> core_rst_n_out)
    else $error("Internal reset not released after hold.");
  a_early_release: assert property ($rose(core_rst_n_out) |-> $past(s.hold_cnt) == '0)
    else $error("Reset released before hold elapsed.");
  a_periph_rst: assert property (1'b1 |=> (per_rst_n_out & $past(prst_flat)) == '0)
    else $error("Peripheral reset bit did not reset.");
  a_cause_sticky: assert property (1'b1 |=> (($past(s.cause) & ~$past(cause_clr) & ~s.cause) == '0))
    else $error("Cause bit lost without a clear.");
  a_por_cause: assert property ($rose(test_rst_n_out) |-> s.cause[CAUSE_POR])
    else $error("Power-on cause bit missing.");

endmodule // mrc_reset_control

// ===== verif/mrc_supply_model.sv
// Model of the reset pin driver and the supply monitor.
`timescale 1ns/10ps
module mrc_supply_model #(
  parameter int MIN_LOW = 3
) (
  // Clock and commands.
  input  wire logic       clk_in,
  input  wire logic       pin_go_in,
  input  wire logic [7:0] pin_len_in,
  input  wire logic       supply_low_in,
  // Lines into the block.
  output logic            ext_rst_n_out,
  output logic            brown_out_out
);
  logic [7:0] cnt_reg = 8'h00;
  // A short request is stretched so the pin is never pulsed below the minimum.
  always @(posedge clk_in) begin
    if (pin_go_in) cnt_reg <= (pin_len_in < MIN_LOW) ? 8'(MIN_LOW) : pin_len_in;
    else if (cnt_reg != 8'h00) cnt_reg <= cnt_reg - 8'h01;
  end
  // The pin has a pull-up, so it sits high once released.
  assign ext_rst_n_out = (cnt_reg == 8'h00);
  assign brown_out_out = supply_low_in;
endmodule // mrc_supply_model

// ===== verif/mrc_reset_control_tb.sv
// Self-checking bench for the reset control block.
`timescale 1ns/10ps
module mrc_reset_control_tb;
  import mrc_pkg::*;
  logic             clk_in = 0, rst_n_in = 0, pin_go = 0, sup_low = 0, wen = 0, err;
  logic [2:0]       ev = 3'h0;
  logic [7:0]       pin_len = 8'h00;
  logic             ext_n, bo, core_n, test_n, pcfg_n, irq;
  logic [PER_W-1:0] per_n;
  logic [31:0]      rd;
  mrc_apb_req_t     req = '0;
  mrc_apb_rsp_t     rsp;
  int               n_fail = 0, checks_done = 0, cyc = 0;
  localparam logic [PER_W-1:0] ONES = '1;
  always #2 clk_in = ~clk_in;
  mrc_supply_model mrc_supply_model_inst (.clk_in(clk_in), .pin_go_in(pin_go), .pin_len_in(pin_len),
    .supply_low_in(sup_low), .ext_rst_n_out(ext_n), .brown_out_out(bo));
  mrc_reset_control mrc_reset_control_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .ext_rst_n_in(ext_n),
    .brown_out_in(bo), .sys_reset_req_in(ev[0]), .wdt_timeout_in(ev[1]), .wdt_int_clear_in(ev[2]),
    .wdt_reset_en_in(wen), .apb_req_in(req), .apb_rsp_out(rsp), .core_rst_n_out(core_n),
    .per_rst_n_out(per_n), .test_rst_n_out(test_n), .pincfg_rst_n_out(pcfg_n), .bor_irq_out(irq));
  task automatic chk(string nm, logic [PER_W-1:0] seen, logic [PER_W-1:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int g;
    g = 0;
    @(posedge clk_in);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_in);
    req.penable <= 1'b1;
    // The answer is looked at mid-cycle, where it is settled, and the request
    // is held until the rising edge that samples pready high.
    do begin
      @(negedge clk_in);
      g++;
    end while (rsp.pready !== 1'b1 && g < 50);
    if (g >= 50) n_fail++;
    rd = rsp.prdata;
    err = rsp.pslverr;
    @(posedge clk_in);
    req <= '0;
  endtask
  task automatic rchk(string nm, logic [11:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask
  task automatic settle(int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic pulse(int i);
    @(posedge clk_in);
    ev[i] <= 1'b1;
    @(posedge clk_in);
    ev[i] <= 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    settle(2);
    chk("core", core_n, 0);
    chk("test", test_n, 1);
    settle(10);
    chk("core", core_n, 1);
    rchk("cause", OFF_CAUSE, 32'h0000_0002);
    rchk("ctrl", OFF_BOR_CTRL, 32'h0000_0000);
    rchk("hole", 12'h0f0, 32'h0000_0000);
    chk("err", err, 1);
    $display("test power-on done");
    apb(1'b1, OFF_PRST2, 32'h8000_0001);
    settle(2);
    chk("per", per_n, {32'h7fff_fffe, 64'hffff_ffff_ffff_ffff});
    chk("core", core_n, 1);
    apb(1'b1, OFF_PRST2, 32'h0000_0000);
    settle(2);
    chk("per", per_n, ONES);
    $display("test peripheral done");
    @(posedge clk_in) sup_low <= 1'b1;
    settle(6);
    chk("irq", irq, 1);
    chk("core", core_n, 1);
    apb(1'b1, OFF_BOR_CTRL, 32'h0000_0002);
    settle(4);
    chk("core", core_n, 0);
    chk("per", per_n, 0);
    chk("test", test_n, 1);
    @(posedge clk_in) sup_low <= 1'b0;
    settle(16);
    chk("core", core_n, 1);
    rchk("cause", OFF_CAUSE, 32'h0000_0006);
    apb(1'b1, OFF_BOR_CTRL, 32'h0000_0000);
    @(posedge clk_in) pin_go <= 1'b1;
    @(posedge clk_in) pin_go <= 1'b0;
    settle(4);
    chk("core", core_n, 0);
    chk("pcfg", pcfg_n, 0);
    chk("test", test_n, 1);
    settle(20);
    chk("core", core_n, 1);
    rchk("cause", OFF_CAUSE, 32'h0000_0007);
    pulse(0);
    settle(2);
    chk("core", core_n, 0);
    chk("test", test_n, 1);
    settle(14);
    chk("core", core_n, 1);
    @(posedge clk_in) wen <= 1'b1;
    pulse(1);
    pulse(2);
    pulse(1);
    settle(3);
    chk("core", core_n, 1);
    pulse(1);
    settle(2);
    chk("core", core_n, 0);
    chk("test", test_n, 1);
    settle(14);
    rchk("cause", OFF_CAUSE, 32'h0000_001f);
    $display("test sources done");
    @(posedge clk_in) rst_n_in <= 1'b0;
    settle(2);
    chk("test", test_n, 0);
    @(posedge clk_in) rst_n_in <= 1'b1;
    settle(12);
    rchk("cause", OFF_CAUSE, 32'h0000_0002);
    apb(1'b1, OFF_CAUSE, 32'h0000_0002);
    rchk("cause", OFF_CAUSE, 32'h0000_0000);
    $display("test cause done");
    tally_and_finish();
  end
endmodule // mrc_reset_control_tb
